// ==== hdl/rst_seq_pkg.sv ====
// constants shared by the reset sequencer and its helpers
package rst_seq_pkg;
  // cycle counts, in internal clock cycles
  localparam int unsigned OSC_STARTUP_CYCLES = 4096;
  localparam int unsigned RECOVERY_CYCLES = 16;
  localparam int unsigned SETTLE_CYCLES = 9;
  localparam int unsigned TIMER_W = 13;

  // fetch vectors (high byte address of each pair)
  localparam logic [15:0] VEC_NORMAL = 16'hFFFE;
  localparam logic [15:0] VEC_CLOCK_FAIL = 16'hFFFC;
  localparam logic [15:0] VEC_WATCHDOG = 16'hFFFA;

  // register byte offsets
  localparam logic [11:0] OFS_INT_CONTROL = 12'h000;
  localparam logic [11:0] OFS_PULLUP_CONTROL = 12'h004;
  localparam logic [11:0] OFS_CCR_MASKS = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_EVENT_STATUS = 12'h010;
  localparam logic [11:0] OFS_EVENT_MASK = 12'h014;

  // field positions
  localparam int unsigned BIT_IRQ_ENABLE = 0;
  localparam int unsigned BIT_IRQ_EDGE = 1;
  localparam int unsigned BIT_PULLUP_ENABLE = 0;
  localparam int unsigned BIT_CCR_I = 0;
  localparam int unsigned BIT_CCR_X = 1;
  localparam int unsigned EV_RESET_DONE = 0;
  localparam int unsigned EV_WATCHDOG = 1;
  localparam int unsigned EV_CLOCK_FAIL = 2;
  localparam int unsigned EV_EXTERNAL = 3;
  localparam int unsigned EV_W = 4;

  // values after reset
  localparam logic [1:0] INT_CONTROL_RST = 2'h1;
  localparam logic PULLUP_ENABLE_RST = 1'b1;
  localparam logic [1:0] CCR_MASKS_RST = 2'h3;
  localparam logic [3:0] EVENT_MASK_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_OSC_WAIT,
    ST_RECOVER,
    ST_SETTLE,
    ST_EXT_WAIT,
    ST_RUN
  } seq_state_t;
endpackage : rst_seq_pkg

// ==== hdl/pin_sync.sv ====
// two-flop synchroniser for a group of pin inputs
module pin_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // pins and synchronised copy
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinSync
);
  logic [W-1:0] stage1_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      stage1_r <= RST_VAL;
      pinSync <= RST_VAL;
    end else begin
      stage1_r <= pinIn;
      pinSync <= stage1_r;
    end
  end
endmodule : pin_sync

// ==== hdl/cycle_timer.sv ====
// loadable down-counter; last is high in the final cycle of a loaded span
module cycle_timer #(
  parameter int unsigned W = 13
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  output logic last
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= loadVal;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign last = (cnt_r == W'(1));
endmodule : cycle_timer

// ==== hdl/reset_pin_sequencer.sv ====
// reset pin sequencer with vector selection, interrupt-pin and mode-pin reset defaults
module reset_pin_sequencer
  import rst_seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset causes
  input wire logic powerOnDetect,
  input wire logic watchdogTimeout,
  input wire logic clockFail,
  // open-drain reset pin
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  // interrupt pins
  input wire logic maskableIntPin,
  input wire logic nonmaskableIntInput,
  output logic intPullupOn,
  output logic maskableIntReq,
  output logic nonmaskableIntReq,
  // mode select pins
  input wire logic specialModePin,
  input wire logic modeSelectA,
  input wire logic modeSelectB,
  output logic modePulldownOn,
  output logic [2:0] opMode,
  // core side
  output logic coreInReset,
  output logic [15:0] resetVector,
  output logic irq
);
  // synchronised pins: reset, power-on, maskable, nonmaskable, mode c/b/a
  logic [6:0] pinSyncd;
  logic resetPinS;
  logic porS;
  logic maskPinS;
  logic nmiPinS;
  logic [2:0] modePinsS;

  pin_sync #(
    .W(7),
    .RST_VAL(7'h1D)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .pinIn({resetPinIn, powerOnDetect, maskableIntPin, nonmaskableIntInput,
            specialModePin, modeSelectB, modeSelectA}),
    .pinSync(pinSyncd)
  );

  assign resetPinS = pinSyncd[6];
  assign porS = pinSyncd[5];
  assign maskPinS = pinSyncd[4];
  assign nmiPinS = pinSyncd[3];
  assign modePinsS = pinSyncd[2:0];

  // sequencer state
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic timerLoad;
  logic [TIMER_W-1:0] timerVal;
  logic timerLast;
  logic watchdogFlag_r;
  logic clockFailFlag_r;
  logic [EV_W-1:0] evSet;

  cycle_timer #(
    .W(TIMER_W)
  ) u_timer (
    .clk(clk),
    .srst(srst),
    .load(timerLoad),
    .loadVal(timerVal),
    .last(timerLast)
  );

  // the timer is empty after srst, so the first cycle out of it starts the startup wait
  logic armed_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= 1'b1;
    end
  end

  // an external low pin seen while running counts as a new reset request
  logic extRequest;
  assign extRequest = (state_r == ST_RUN) && !resetPinS;

  always_comb begin
    state_nxt = state_r;
    timerLoad = 1'b0;
    timerVal = '0;
    evSet = '0;
    if (porS || clockFail || !armed_r) begin
      // startup delay restarts for as long as the cause persists
      state_nxt = ST_OSC_WAIT;
      timerLoad = 1'b1;
      timerVal = TIMER_W'(OSC_STARTUP_CYCLES);
    end else begin
      case (state_r)
        ST_OSC_WAIT: begin
          if (timerLast) begin
            state_nxt = ST_RECOVER;
            timerLoad = 1'b1;
            timerVal = TIMER_W'(RECOVERY_CYCLES);
          end
        end
        ST_RECOVER: begin
          if (timerLast) begin
            state_nxt = ST_SETTLE;
            timerLoad = 1'b1;
            timerVal = TIMER_W'(SETTLE_CYCLES);
          end
        end
        ST_SETTLE: begin
          if (timerLast) begin
            if (!resetPinS) begin
              state_nxt = ST_EXT_WAIT;
              evSet[EV_EXTERNAL] = 1'b1;
            end else begin
              state_nxt = ST_RUN;
              evSet[EV_RESET_DONE] = 1'b1;
              evSet[EV_CLOCK_FAIL] = clockFailFlag_r;
              evSet[EV_WATCHDOG] = !clockFailFlag_r && watchdogFlag_r;
            end
          end
        end
        ST_EXT_WAIT: begin
          if (resetPinS) begin
            state_nxt = ST_RUN;
            evSet[EV_RESET_DONE] = 1'b1;
          end
        end
        ST_RUN: begin
          if (watchdogTimeout || extRequest) begin
            state_nxt = ST_RECOVER;
            timerLoad = 1'b1;
            timerVal = TIMER_W'(RECOVERY_CYCLES);
          end
        end
        default: begin
          state_nxt = ST_OSC_WAIT;
          timerLoad = 1'b1;
          timerVal = TIMER_W'(OSC_STARTUP_CYCLES);
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_OSC_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // latched fault causes survive until the vector is chosen
  always_ff @(posedge clk) begin
    if (srst) begin
      watchdogFlag_r <= 1'b0;
      clockFailFlag_r <= 1'b0;
    end else begin
      if (clockFail) begin
        clockFailFlag_r <= 1'b1;
      end else if (state_r == ST_SETTLE && timerLast) begin
        clockFailFlag_r <= 1'b0;
      end
      if (watchdogTimeout) begin
        watchdogFlag_r <= 1'b1;
      end else if (state_r == ST_SETTLE && timerLast) begin
        watchdogFlag_r <= 1'b0;
      end
    end
  end

  // core reset and vector selection
  always_ff @(posedge clk) begin
    if (srst) begin
      coreInReset <= 1'b1;
      resetVector <= VEC_NORMAL;
    end else begin
      coreInReset <= (state_nxt != ST_RUN);
      if (state_r == ST_SETTLE && timerLast) begin
        if (!resetPinS) begin
          resetVector <= VEC_NORMAL;
        end else if (clockFailFlag_r) begin
          resetVector <= VEC_CLOCK_FAIL;
        end else if (watchdogFlag_r) begin
          resetVector <= VEC_WATCHDOG;
        end else begin
          resetVector <= VEC_NORMAL;
        end
      end
    end
  end

  // reset pin drive: low through startup and recovery, released for settle
  always_ff @(posedge clk) begin
    if (srst) begin
      resetPinOe <= 1'b1;
      resetPinOut <= 1'b0;
    end else begin
      resetPinOe <= (state_nxt == ST_OSC_WAIT) || (state_nxt == ST_RECOVER);
      resetPinOut <= 1'b0;
    end
  end

  // software control registers
  logic [1:0] intControl_r;
  logic pullupEnable_r;
  logic [1:0] ccrMasks_r;
  logic [EV_W-1:0] evStatus_r;
  logic [EV_W-1:0] evMask_r;
  logic wrAcc;
  logic [EV_W-1:0] evClear;

  assign wrAcc = psel && penable && pready && pwrite;
  assign evClear = (wrAcc && paddr == OFS_EVENT_STATUS) ? pwdata[EV_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (srst || coreInReset) begin
      intControl_r <= INT_CONTROL_RST;
      pullupEnable_r <= PULLUP_ENABLE_RST;
      ccrMasks_r <= CCR_MASKS_RST;
    end else if (wrAcc) begin
      if (paddr == OFS_INT_CONTROL) begin
        intControl_r <= pwdata[1:0];
      end
      if (paddr == OFS_PULLUP_CONTROL) begin
        pullupEnable_r <= pwdata[BIT_PULLUP_ENABLE];
      end
      if (paddr == OFS_CCR_MASKS) begin
        // the nonmaskable mask can only be cleared, never set again by software
        ccrMasks_r[BIT_CCR_I] <= pwdata[BIT_CCR_I];
        ccrMasks_r[BIT_CCR_X] <= ccrMasks_r[BIT_CCR_X] & pwdata[BIT_CCR_X];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      evStatus_r <= '0;
      evMask_r <= EVENT_MASK_RST;
    end else begin
      // a new event wins over a clear in the same cycle
      evStatus_r <= (evStatus_r & ~evClear) | evSet;
      if (wrAcc && paddr == OFS_EVENT_MASK) begin
        evMask_r <= pwdata[EV_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evStatus_r & evMask_r);
    end
  end

  // interrupt pins; shared lines rely on sources holding low until serviced
  logic maskPinPrev_r;
  logic edgeSeen_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      maskPinPrev_r <= 1'b1;
      edgeSeen_r <= 1'b0;
      maskableIntReq <= 1'b0;
      nonmaskableIntReq <= 1'b0;
      intPullupOn <= 1'b1;
    end else begin
      maskPinPrev_r <= maskPinS;
      if (maskPinPrev_r && !maskPinS && intControl_r[BIT_IRQ_EDGE]) begin
        edgeSeen_r <= 1'b1;
      end else if (!intControl_r[BIT_IRQ_EDGE] || !ccrMasks_r[BIT_CCR_I]) begin
        edgeSeen_r <= 1'b0;
      end
      maskableIntReq <= intControl_r[BIT_IRQ_ENABLE] && !ccrMasks_r[BIT_CCR_I]
        && (intControl_r[BIT_IRQ_EDGE] ? edgeSeen_r : !maskPinS);
      nonmaskableIntReq <= !ccrMasks_r[BIT_CCR_X] && !nmiPinS;
      // follows the sequencer directly so the pull-ups come on with coreInReset
      intPullupOn <= (state_nxt != ST_RUN) || pullupEnable_r;
    end
  end

  // mode pins follow the pins during reset and freeze when it ends
  always_ff @(posedge clk) begin
    if (srst) begin
      opMode <= 3'h0;
      modePulldownOn <= 1'b1;
    end else begin
      if (coreInReset) begin
        opMode <= modePinsS;
      end
      modePulldownOn <= (state_nxt != ST_RUN);
    end
  end

  // apb: read data captured in the setup cycle, answer in the first access cycle
  logic addrOk;
  logic [31:0] rdMux;

  always_comb begin
    addrOk = 1'b1;
    rdMux = 32'h0;
    case (paddr)
      OFS_INT_CONTROL: rdMux = {30'h0, intControl_r};
      OFS_PULLUP_CONTROL: rdMux = {31'h0, pullupEnable_r};
      OFS_CCR_MASKS: rdMux = {30'h0, ccrMasks_r};
      OFS_STATUS: rdMux = {resetVector, 4'h0, 1'b0, opMode, 1'b0, state_r,
                           watchdogFlag_r, clockFailFlag_r, resetPinS, coreInReset};
      OFS_EVENT_STATUS: rdMux = {28'h0, evStatus_r};
      OFS_EVENT_MASK: rdMux = {28'h0, evMask_r};
      default: addrOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0 : rdMux;
      end
    end
  end
endmodule : reset_pin_sequencer

// ==== verification/reset_seq_props.sv ====
// concurrent checks on the reset pin sequencer ports
module reset_seq_props
  import rst_seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // causes
  input wire logic watchdogTimeout,
  input wire logic clockFail,
  // outputs
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic intPullupOn,
  input wire logic modePulldownOn,
  input wire logic [2:0] opMode,
  input wire logic coreInReset,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [12:0] oeRun_r;
  // cleared on clock failure, which restarts the long wait
  always_ff @(posedge clk) begin
    if (srst || clockFail || !resetPinOe) oeRun_r <= 13'h0000;
    else oeRun_r <= oeRun_r + 13'h0001;
  end
  sequence s_low16; resetPinOe [*8] ##1 resetPinOe [*8]; endsequence
  // counts settle cycles: core held in reset while the pin is released
  logic [3:0] settleRun_r;
  always_ff @(posedge clk) begin
    if (srst || !coreInReset || resetPinOe) settleRun_r <= 4'h0;
    else settleRun_r <= settleRun_r + 4'h1;
  end
  sequence s_settle; ##8 (settleRun_r == 4'h8 && coreInReset && !resetPinOe); endsequence
  property p_entry; watchdogTimeout && !coreInReset |=> resetPinOe && coreInReset; endproperty
  a_entry: assert property (p_entry) else $error("no entry on watchdog");
  property p_rec; watchdogTimeout && !coreInReset && !clockFail |=> s_low16 ##1 !resetPinOe;
  endproperty
  a_rec: assert property (p_rec) else $error("recovery length wrong");
  property p_settle; $fell(resetPinOe) && !clockFail |-> s_settle; endproperty
  a_settle: assert property (p_settle) else $error("settle span wrong");
  property p_exit; $fell(coreInReset) |-> !resetPinOe && !$past(resetPinOe, 9); endproperty
  a_exit: assert property (p_exit) else $error("exit before settle");
  property p_od; resetPinOut == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin data not low");
  property p_oe; resetPinOe |-> coreInReset; endproperty
  a_oe: assert property (p_oe) else $error("pin driven outside reset");
  property p_span; $fell(resetPinOe) |->
    oeRun_r inside {[13'h0010:13'h0011], [13'h1010:13'h1012]}; endproperty
  a_span: assert property (p_span) else $error("low drive span wrong");
  property p_fail; clockFail |=> resetPinOe; endproperty
  a_fail: assert property (p_fail) else $error("no drive on clock fail");
  property p_pulls; coreInReset |-> intPullupOn && modePulldownOn; endproperty
  a_pulls: assert property (p_pulls) else $error("pulls off in reset");
  property p_mode; !coreInReset && !$past(coreInReset) |-> $stable(opMode); endproperty
  a_mode: assert property (p_mode) else $error("mode changed in run");
  property p_rst; disable iff (1'b0) srst |=> resetPinOe && coreInReset && intPullupOn && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : reset_seq_props

// ==== verification/reset_pin_partner.sv ====
// open-drain reset line with pull-up and an outside reset source
module reset_pin_partner #(
  parameter int unsigned RISE_CYCLES = 3
) (
  // clock
  input wire logic clk,
  // drivers
  input wire logic resetPinOe,
  input wire logic extHold,
  // line level
  output logic resetPinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] riseCnt_r;
  // the pull-up lifts the line a few cycles after every driver lets go
  always_ff @(posedge clk) begin
    if (resetPinOe || extHold) riseCnt_r <= 4'h0;
    else if (riseCnt_r != 4'hF) riseCnt_r <= riseCnt_r + 4'h1;
  end
  assign resetPinIn = !(resetPinOe || extHold) && (riseCnt_r >= 4'(RISE_CYCLES));
endmodule : reset_pin_partner

// ==== verification/tb.sv ====
// testbench for the reset pin sequencer
module tb
  import rst_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic powerOnDetect, watchdogTimeout, clockFail, extHold;
  logic resetPinIn, resetPinOut, resetPinOe, intPullupOn, modePulldownOn, coreInReset, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] opMode, modePins;
  logic maskPin, nmiPin, maskableIntReq, nonmaskableIntReq;
  logic [15:0] resetVector;
  int failures, checks_done, cyc;
  reset_pin_sequencer dut_u (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .powerOnDetect, .watchdogTimeout, .clockFail, .resetPinIn,
    .resetPinOut, .resetPinOe, .maskableIntPin(maskPin), .nonmaskableIntInput(nmiPin),
    .intPullupOn, .maskableIntReq, .nonmaskableIntReq, .specialModePin(modePins[2]),
    .modeSelectA(modePins[0]), .modeSelectB(modePins[1]), .modePulldownOn, .opMode,
    .coreInReset, .resetVector, .irq);
  reset_pin_partner part_u (.clk, .resetPinOe, .extHold, .resetPinIn);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 25000) begin
      failures++;
      test_done;
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready and read data are taken as they stand at the rising edge
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rchk
  // events are read, compared and then cleared by writing ones
  task ev(input logic [31:0] exp);
    rchk(OFS_EVENT_STATUS, exp, "event_status");
    apb(1'b1, OFS_EVENT_STATUS, 32'h0000000F);
    // irq is registered from the status, one cycle behind the clear
    repeat (2) @(negedge clk);
  endtask : ev
  task kick(input int k);
    @(posedge clk);
    case (k)
      0: watchdogTimeout <= 1'b1;
      1: {clockFail, watchdogTimeout} <= 2'b11;
      2: powerOnDetect <= 1'b1;
      default: {extHold, watchdogTimeout} <= 2'b11;
    endcase
    @(posedge clk);
    {clockFail, watchdogTimeout, powerOnDetect} <= 3'h0;
    repeat (4) @(negedge clk);
    chk("coreInReset", {31'h0, coreInReset & resetPinOe}, 32'h1);
    do @(negedge clk); while (coreInReset !== 1'b0);
  endtask : kick
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'h0, 12'h000, 32'h0};
    {powerOnDetect, watchdogTimeout, clockFail, extHold} = 4'h0;
    {maskPin, nmiPin, modePins} = 5'h1D;
    {failures, checks_done, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    apb(1'b1, OFS_INT_CONTROL, 32'h0);
    rchk(OFS_INT_CONTROL, 32'h1, "int_control_reg");
    rchk(OFS_PULLUP_CONTROL, 32'h1, "pullup_control_reg");
    rchk(OFS_CCR_MASKS, 32'h3, "ccr_masks");
    rchk(OFS_EVENT_MASK, 32'h0, "event_mask");
    rchk(12'h018, 32'h0, "unmapped");
    chk("pslverr", {31'h0, err}, 32'h1);
    $display("test reset_defaults done");
    do @(negedge clk); while (coreInReset !== 1'b0);
    chk("resetVector", {16'h0, resetVector}, {16'h0, VEC_NORMAL});
    chk("opMode", {29'h0, opMode}, 32'h5);
    ev(32'h1);
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1'b1, OFS_INT_CONTROL, 32'h2);
    rchk(OFS_INT_CONTROL, 32'h2, "int_control_reg");
    apb(1'b1, OFS_PULLUP_CONTROL, 32'h0);
    repeat (2) @(negedge clk);
    chk("intPullupOn", {31'h0, intPullupOn}, 32'h0);
    apb(1'b1, OFS_CCR_MASKS, 32'h0);
    // sources hold both lines low until seen; mode pins move outside reset
    {maskPin, nmiPin, modePins} <= 5'h02;
    repeat (4) @(negedge clk);
    chk("maskableIntReq", {31'h0, maskableIntReq}, 32'h0);
    chk("nonmaskableIntReq", {31'h0, nonmaskableIntReq}, 32'h1);
    chk("opMode", {29'h0, opMode}, 32'h5);
    @(posedge clk);
    {maskPin, nmiPin} <= 2'b11;
    apb(1'b1, OFS_CCR_MASKS, 32'h3);
    rchk(OFS_CCR_MASKS, 32'h1, "ccr_masks");
    apb(1'b1, OFS_EVENT_MASK, 32'h2);
    $display("test power_up_and_software done");
    kick(0);
    chk("resetVector", {16'h0, resetVector}, {16'h0, VEC_WATCHDOG});
    chk("opMode", {29'h0, opMode}, 32'h2);
    chk("intPullupOn", {31'h0, intPullupOn}, 32'h1);
    rchk(OFS_INT_CONTROL, 32'h1, "int_control_reg");
    rchk(OFS_CCR_MASKS, 32'h3, "ccr_masks");
    nmiPin <= 1'b0;
    repeat (4) @(negedge clk);
    chk("nonmaskableIntReq", {31'h0, nonmaskableIntReq}, 32'h0);
    @(posedge clk);
    nmiPin <= 1'b1;
    chk("irq", {31'h0, irq}, 32'h1);
    ev(32'h3);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test watchdog done");
    kick(1);
    chk("resetVector", {16'h0, resetVector}, {16'h0, VEC_CLOCK_FAIL});
    ev(32'h5);
    $display("test clock_fail done");
    fork
      kick(3);
      begin
        repeat (60) @(posedge clk);
        extHold <= 1'b0;
      end
    join
    chk("resetVector", {16'h0, resetVector}, {16'h0, VEC_NORMAL});
    ev(32'h9);
    $display("test external done");
    kick(2);
    chk("resetVector", {16'h0, resetVector}, {16'h0, VEC_NORMAL});
    ev(32'h1);
    $display("test power_on done");
    test_done;
  end
endmodule : tb
bind reset_pin_sequencer reset_seq_props props_u (.clk, .srst, .watchdogTimeout, .clockFail,
  .resetPinOut, .resetPinOe, .intPullupOn, .modePulldownOn, .opMode, .coreInReset, .irq);
